/* sbc_pkg.sv */
/*
 Constants for the stack bounds checker: reserved word addresses,
 underflow floor, field positions, reset values and widths.
 Assumes a 16-bit word machine where bit 0 is the most significant bit.
*/
// Notes on behaviour
// R01 - Program starts stack at 401 octal, pointer 400
// R02 - Bit 0 set in both disables underflow; the code tests bit 0 of the limit only
// R03 - Program sets limit above the initial pointer
// R04 - Program keeps limit ten/twenty-three words below end
// R05 - Program loads fault handler address at 43 octal
// R06 - Program sets frame pointer equal to pointer
// R07 - Check overflow on every push, after writing
// R08 - Some pushes may check overflow before writing
// R09 - Overflow when pointer strictly greater than limit
// R10 - Check underflow after every pop
// R11 - Underflow when pointer below 400 and bit clear
// R12 - Pointer moves one per word pushed or popped
// R13 - Pointer at 40 octal, limit at 42 octal
// R14 - Fault jumps to handler held at 43 octal
// R15 - Frame pointer at 41, untouched by push/pop
package sbc_pkg;
	localparam int unsigned WORD_W     = 16;
	localparam int unsigned COUNT_W    = 5;
	// Reserved low-memory word addresses (40 to 43 octal)
	localparam logic [15:0] ADDR_PTR   = 16'h0020;
	localparam logic [15:0] ADDR_FRAME = 16'h0021;
	localparam logic [15:0] ADDR_LIMIT = 16'h0022;
	localparam logic [15:0] ADDR_FAULT = 16'h0023;
	// Lowest legal pointer value (400 octal)
	localparam logic [15:0] UNF_FLOOR  = 16'h0100;
	// Bit 0 in the machine's numbering is the msb
	localparam int unsigned DIS_BIT    = 15;
	// Reset values of the reserved words
	localparam logic [15:0] PTR_RST    = 16'h0000;
	localparam logic [15:0] FRAME_RST  = 16'h0000;
	localparam logic [15:0] LIMIT_RST  = 16'h0000;
	localparam logic [15:0] FAULT_RST  = 16'h0000;
endpackage

/* sbc_chk_if.sv */
/*
 Carrier between the stack parameter keeper and the bounds comparator.
 Assumes both ends sit in the same clock domain.
*/
`timescale 1ns/1ns
interface sbc_chk_if;
	logic [15:0] new_ptr;
	logic [15:0] limit;
	logic        over;
	logic        under;
	modport keeper (output new_ptr, output limit, input over, input under);
	modport cmp    (input new_ptr, input limit, output over, output under);
endinterface

/* sbc_cmp.sv */
/*
 Combinational bounds comparator for the stack bounds checker.
 Assumes the keeper presents the candidate pointer and the current limit.
*/
`timescale 1ns/1ns
module sbc_cmp (
	// Operands and verdicts
	sbc_chk_if.cmp chk
);
	wire unf_enabled;

	// Overflow is a strict unsigned greater-than against the limit
	assign chk.over    = chk.new_ptr > chk.limit; // R09
	// Underflow only while the limit's disable bit is clear
	assign unf_enabled = ~chk.limit[sbc_pkg::DIS_BIT]; // R02
	assign chk.under   = unf_enabled && (chk.new_ptr < sbc_pkg::UNF_FLOOR); // R11
endmodule // sbc_cmp

/* sbc_top.sv */
/*
 Stack bounds checker: keeps pointer, frame pointer, limit and fault
 handler address, moves the pointer on pushes and pops, and raises a
 one-cycle stack fault on overflow or underflow.
 Assumes the processor issues at most one push or pop per cycle and
 stores to reserved words through the write port.
*/
`timescale 1ns/1ns
module sbc_top (
	// Clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        ARST_N,
	// Reserved word stores
	input  wire logic        WR_EN,
	input  wire logic [15:0] WR_ADDR,
	input  wire logic [15:0] WR_DATA,
	// Stack operations
	input  wire logic        PUSH_REQ,
	input  wire logic        POP_REQ,
	input  wire logic [4:0]  OP_WORDS,
	input  wire logic        PRE_CHECK,
	// Stack parameters
	output logic      [15:0] STACK_TOP_POINTER,
	output logic      [15:0] FRAME_ANCHOR_POINTER,
	output logic      [15:0] STACK_CEILING_VALUE,
	output logic      [15:0] FAULT_HANDLER,
	// Fault report
	output logic             FAULT_PULSE,
	output logic             FAULT_OVF,
	output logic             FAULT_UNF,
	output logic      [15:0] FAULT_TARGET
);
	logic [15:0] ptr_reg;
	logic [15:0] ptr_next;
	logic [15:0] frame_reg;
	logic [15:0] limit_reg;
	logic [15:0] handler_reg;
	logic        ovf_reg;
	logic        unf_reg;
	logic [15:0] target_reg;

	wire         do_push;
	wire         do_pop;
	wire  [15:0] words;
	wire  [15:0] cand_ptr;
	wire         ovf_hit;
	wire         unf_hit;
	wire         pre_block;
	wire         wr_ptr;
	wire         wr_frame;
	wire         wr_limit;
	wire         wr_fault;

	sbc_chk_if chk ();

	sbc_cmp sbc_cmp_inst (
		.chk (chk.cmp)
	);

	// Operation decode; push wins if both are requested
	assign do_push  = PUSH_REQ;
	assign do_pop   = POP_REQ && !PUSH_REQ;
	assign words    = {11'h000, OP_WORDS};
	// Pointer moves by one per word transferred
	assign cand_ptr = do_push ? ptr_reg + words : ptr_reg - words; // R12

	// Comparator sees the candidate pointer and the current limit
	assign chk.new_ptr = cand_ptr;
	assign chk.limit   = limit_reg;
	// Overflow checked on every push, underflow on every pop
	assign ovf_hit     = do_push && chk.over; // R07
	assign unf_hit     = do_pop && chk.under; // R10
	// Pre-checked push that would overflow writes nothing
	assign pre_block   = ovf_hit && PRE_CHECK; // R08

	// Reserved word store decode
	assign wr_ptr   = WR_EN && (WR_ADDR == sbc_pkg::ADDR_PTR); // R13
	assign wr_frame = WR_EN && (WR_ADDR == sbc_pkg::ADDR_FRAME); // R15
	assign wr_limit = WR_EN && (WR_ADDR == sbc_pkg::ADDR_LIMIT); // R13
	assign wr_fault = WR_EN && (WR_ADDR == sbc_pkg::ADDR_FAULT); // R14

	// Next pointer: stack operations win over a store in the same cycle, except a push blocked by the pre-check
	assign ptr_next = ((do_push || do_pop) && !pre_block) ? cand_ptr : // R12
	                  (wr_ptr ? WR_DATA : ptr_reg);

	// Stack parameter words
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ptr_reg     <= sbc_pkg::PTR_RST;
			frame_reg   <= sbc_pkg::FRAME_RST;
			limit_reg   <= sbc_pkg::LIMIT_RST;
			handler_reg <= sbc_pkg::FAULT_RST;
		end else begin
			ptr_reg <= ptr_next;
			if (wr_frame) begin
				frame_reg <= WR_DATA; // R15
			end
			if (wr_limit) begin
				limit_reg <= WR_DATA;
			end
			if (wr_fault) begin
				handler_reg <= WR_DATA;
			end
		end
	end

	// Fault report, one cycle after the offending operation
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ovf_reg    <= 1'b0;
			unf_reg    <= 1'b0;
			target_reg <= sbc_pkg::FAULT_RST;
		end else begin
			ovf_reg <= ovf_hit; // R09
			unf_reg <= unf_hit; // R11
			if (ovf_hit || unf_hit) begin
				target_reg <= handler_reg; // R14
			end
		end
	end

	// Outputs straight from flip-flops, except FAULT_PULSE, the OR of the two flags
	assign STACK_TOP_POINTER    = ptr_reg;
	assign FRAME_ANCHOR_POINTER = frame_reg;
	assign STACK_CEILING_VALUE  = limit_reg;
	assign FAULT_HANDLER        = handler_reg;
	assign FAULT_OVF            = ovf_reg;
	assign FAULT_UNF            = unf_reg;
	assign FAULT_PULSE          = ovf_reg || unf_reg;
	assign FAULT_TARGET         = target_reg;

	// Push moves the pointer up by the word count unless blocked
	a_push_moves_up: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // R12
		(PUSH_REQ && !PRE_CHECK) |=> (ptr_reg == $past(ptr_reg) + {11'h000, $past(OP_WORDS)}))
		else $error("Pointer did not advance on push");

	// Pop moves the pointer down by the word count
	a_pop_moves_down: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // R12
		(POP_REQ && !PUSH_REQ) |=> (ptr_reg == $past(ptr_reg) - {11'h000, $past(OP_WORDS)}))
		else $error("Pointer did not retreat on pop");

	// Overflow flag follows the strict comparison after a push
	a_ovf_verdict: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // R09
		(PUSH_REQ && !PRE_CHECK) |=> (FAULT_OVF == (ptr_reg > $past(limit_reg))))
		else $error("Overflow flag disagrees with pointer and limit");

	// Underflow flag follows floor and disable bit after a pop
	a_unf_verdict: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // R11
		(POP_REQ && !PUSH_REQ) |=> (FAULT_UNF ==
		((ptr_reg < sbc_pkg::UNF_FLOOR) && !$past(limit_reg[sbc_pkg::DIS_BIT]))))
		else $error("Underflow flag disagrees with pointer and floor");

	// Disable bit in the limit suppresses underflow altogether
	a_unf_disabled: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // R02
		limit_reg[sbc_pkg::DIS_BIT] |=> !FAULT_UNF)
		else $error("Underflow raised while checking disabled");

	// Pre-checked overflowing push leaves the pointer alone
	a_pre_holds: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // R08
		(PUSH_REQ && PRE_CHECK && !wr_ptr) ##1 FAULT_OVF |-> $stable(ptr_reg))
		else $error("Blocked push still moved the pointer");

	// Fault carries the handler address held at the fault word
	a_fault_target: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // R14
		FAULT_PULSE |-> (FAULT_TARGET == $past(handler_reg)))
		else $error("Fault target is not the handler address");

	// Frame pointer changes only by a store to its word
	a_frame_steady: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // R15
		!wr_frame |=> $stable(frame_reg))
		else $error("Frame pointer changed without a store");

	// Store to the pointer word loads the pointer when no operation runs
	a_ptr_store: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // R13
		(wr_ptr && !PUSH_REQ && !POP_REQ) |=> (ptr_reg == $past(WR_DATA)))
		else $error("Pointer store did not take");

	// Every push is followed by a one-cycle overflow verdict only
	a_push_no_unf: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // R07
		PUSH_REQ |=> !FAULT_UNF)
		else $error("Push produced an underflow report");

	// A pop never reports an overflow
	a_pop_no_ovf: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // R07
		(POP_REQ && !PUSH_REQ) |=> !FAULT_OVF)
		else $error("Pop produced an overflow report");

	// Overflow report only follows a push
	a_ovf_push_only: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // R07
		FAULT_OVF |-> $past(PUSH_REQ))
		else $error("Overflow reported without a push");

	// Underflow report only follows a pop
	a_unf_pop_only: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // R10
		FAULT_UNF |-> $past(POP_REQ && !PUSH_REQ))
		else $error("Underflow reported without a pop");

	// Pre-checked push judges the pointer it would reach
	a_pre_verdict: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // R08
		(PUSH_REQ && PRE_CHECK) |=> (FAULT_OVF == (($past(ptr_reg) + {11'h000, $past(OP_WORDS)}) > $past(limit_reg))))
		else $error("Pre-checked overflow verdict is wrong");

	// Pointer holds while nothing moves or stores it
	a_ptr_idle_hold: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // R12
		(!PUSH_REQ && !POP_REQ && !wr_ptr) |=> $stable(ptr_reg))
		else $error("Pointer moved without a cause");

	// Store to the limit word loads the limit
	a_limit_store: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // R13
		wr_limit |=> (limit_reg == $past(WR_DATA)))
		else $error("Limit store did not take");

	// Store to the frame word loads the frame pointer
	a_frame_store: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // R15
		wr_frame |=> (frame_reg == $past(WR_DATA)))
		else $error("Frame pointer store did not take");

	// Store to the fault word loads the handler address
	a_handler_store: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // R14
		wr_fault |=> (handler_reg == $past(WR_DATA)))
		else $error("Handler store did not take");

	// Fault target only changes on a fault
	a_target_steady: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // R14
		!(ovf_hit || unf_hit) |=> $stable(target_reg))
		else $error("Fault target changed without a fault");
endmodule // sbc_top

/* sbc_prog_model.sv */
/*
 Program-side model: stores the stack parameters into the reserved words.
 Assumes the bench raises start while no stack operation is pending.
*/
`timescale 1ns/1ns
module sbc_prog_model (
	// Clock and command
	input  wire logic        clk,
	input  wire logic        start,
	input  wire logic [15:0] ptr_val,
	input  wire logic [15:0] lim_val,
	input  wire logic [15:0] hnd_val,
	// Store port
	output logic             wr_en,
	output logic      [15:0] wr_addr,
	output logic      [15:0] wr_data,
	output logic             done
);
	// Picks the address and data of store i
	function automatic logic [31:0] sel(input int i);
		case (i)
			0: return {sbc_pkg::ADDR_PTR, ptr_val};
			1: return {sbc_pkg::ADDR_FRAME, ptr_val};
			2: return {sbc_pkg::ADDR_LIMIT, lim_val};
			3: return {sbc_pkg::ADDR_FAULT, hnd_val};
			default: return {16'h0024, 16'hFFFF};
		endcase
	endfunction
	// One store a cycle, then released lines show the inverse
	initial begin
		wr_addr = 16'h0000;
		wr_data = 16'h0000;
		forever begin
			wr_en = 1'b0;
			done = 1'b0;
			wait (start === 1'b1);
			for (int i = 0; i < 5; i++) begin
				@(posedge clk);
				#1;
				wr_en = 1'b1;
				{wr_addr, wr_data} = sel(i);
			end
			@(posedge clk);
			#1;
			wr_en = 1'b0;
			wr_addr = ~wr_addr;
			wr_data = ~wr_data;
			done = 1'b1;
			wait (start === 1'b0);
		end
	end
endmodule // sbc_prog_model

/* stack_bounds_checker_tb_top.sv */
/*
 Self-checking bench for the stack bounds checker.
 Assumes one-cycle answer latency on every push or pop.
*/
`timescale 1ns/1ns
module stack_bounds_checker_tb_top;
	typedef struct packed {logic [15:0] p, f, l, h, t; logic o, u, pl;} sbc_note_s;
	logic SYS_CLK = 1'b0, ARST_N = 1'b0, PUSH_REQ = 1'b0, POP_REQ = 1'b0, PRE_CHECK = 1'b0, start = 1'b0;
	logic [4:0]  OP_WORDS = 5'h00;
	logic [15:0] ptr_v = 16'h0000, lim_v = 16'h0000, hnd_v = 16'h0000, ep = 16'h0000, ef = 16'h0000;
	logic [15:0] el = 16'h0000, eh = 16'h0000, et = 16'h0000, WR_ADDR, WR_DATA;
	logic [15:0] STACK_TOP_POINTER, FRAME_ANCHOR_POINTER, STACK_CEILING_VALUE, FAULT_HANDLER, FAULT_TARGET;
	logic        WR_EN, done, FAULT_PULSE, FAULT_OVF, FAULT_UNF;
	int          fails = 0, checks_done = 0, r;
	sbc_note_s   notes[$], exp;
	// Clock
	always #5 SYS_CLK = ~SYS_CLK;
	sbc_prog_model sbc_prog_model_inst (.clk(SYS_CLK), .start(start), .ptr_val(ptr_v), .lim_val(lim_v),
		.hnd_val(hnd_v), .wr_en(WR_EN), .wr_addr(WR_ADDR), .wr_data(WR_DATA), .done(done));
	sbc_top sbc_top_inst (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .WR_EN(WR_EN), .WR_ADDR(WR_ADDR),
		.WR_DATA(WR_DATA), .PUSH_REQ(PUSH_REQ), .POP_REQ(POP_REQ), .OP_WORDS(OP_WORDS), .PRE_CHECK(PRE_CHECK),
		.STACK_TOP_POINTER(STACK_TOP_POINTER), .FRAME_ANCHOR_POINTER(FRAME_ANCHOR_POINTER),
		.STACK_CEILING_VALUE(STACK_CEILING_VALUE), .FAULT_HANDLER(FAULT_HANDLER), .FAULT_PULSE(FAULT_PULSE),
		.FAULT_OVF(FAULT_OVF), .FAULT_UNF(FAULT_UNF), .FAULT_TARGET(FAULT_TARGET));
	// Has the program model store all parameters
	task automatic init(input logic [15:0] p, l, h);
		ptr_v = p;
		lim_v = l;
		hnd_v = h;
		start = 1'b1;
		for (int k = 0; k < 20 && done !== 1'b1; k++) @(posedge SYS_CLK);
		#1;
		start = 1'b0;
		{ep, ef, el, eh} = {p, p, l, h};
	endtask
	// Issues one operation and notes its expected outcome
	task automatic op(input logic push, pre, input logic [4:0] n);
		sbc_note_s e;
		logic [15:0] np;
		np = push ? ep + {11'h000, n} : ep - {11'h000, n};
		e.o = push && (np > el);
		e.u = !push && (np < sbc_pkg::UNF_FLOOR) && !el[sbc_pkg::DIS_BIT];
		if (!(push && pre && e.o)) ep = np;
		if (e.o || e.u) et = eh;
		{e.p, e.f, e.l, e.h, e.t, e.pl} = {ep, ef, el, eh, et, e.o | e.u};
		notes.push_back(e);
		{PUSH_REQ, POP_REQ, PRE_CHECK, OP_WORDS} = {push, !push, pre, n};
		@(posedge SYS_CLK);
		#1;
	endtask
	task automatic idle(input string name);
		{PUSH_REQ, POP_REQ, PRE_CHECK} = 3'b000;
		@(posedge SYS_CLK);
		#1;
		$display("Test %s done", name);
	endtask
	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Monitor: compares each answer with the oldest note
	always @(posedge SYS_CLK) begin
		if (ARST_N === 1'b1 && (PUSH_REQ || POP_REQ)) begin
			#2;
			exp = notes.pop_front();
			checks_done++;
			if ({STACK_TOP_POINTER, FRAME_ANCHOR_POINTER, STACK_CEILING_VALUE, FAULT_HANDLER, FAULT_TARGET,
				FAULT_OVF, FAULT_UNF, FAULT_PULSE} !== exp) begin
				fails++;
				$display("ERROR stack state expected %h seen %h", exp, {STACK_TOP_POINTER,
					FRAME_ANCHOR_POINTER, STACK_CEILING_VALUE, FAULT_HANDLER, FAULT_TARGET, FAULT_OVF,
					FAULT_UNF, FAULT_PULSE});
			end
		end
	end
	// Main sequence
	initial begin
		r = $urandom(32'h374f);
		repeat (8) @(posedge SYS_CLK);
		#1;
		ARST_N = 1'b1;
		op(1'b1, 1'b0, 5'd0);
		idle("reset");
		init(16'h0100, 16'h0110, 16'h0A5A);
		op(1'b1, 1'b0, 5'd16);
		op(1'b1, 1'b0, 5'd1);
		op(1'b0, 1'b0, 5'd1);
		idle("overflow");
		op(1'b1, 1'b1, 5'd2);
		idle("precheck");
		repeat (8) op(1'b0, 1'b0, 5'($urandom_range(1, 4)));
		op(1'b0, 1'b0, 5'd31);
		idle("underflow");
		init(16'h0010, 16'h8020, 16'h0777);
		op(1'b0, 1'b0, 5'd2);
		op(1'b1, 1'b1, 5'd31);
		idle("disable");
		repeat (2) @(posedge SYS_CLK);
		tally_and_finish();
	end
	// Watchdog
	initial begin
		#5000;
		fails++;
		tally_and_finish();
	end
endmodule // stack_bounds_checker_tb_top
